// ===== diag_source_pkg.sv
// Constants and types for the per-channel diagnostic source selectors
package diag_source_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam int unsigned   REG_ADDR_W        = 8;
    localparam int unsigned   REG_DATA_W        = 8;
    localparam logic [7:0]    ADDR_SEL_CH1_CH2  = 8'h28;
    localparam logic [7:0]    ADDR_SEL_CH3_CH4  = 8'h29;
    localparam logic [7:0]    SEL_REG_RESET     = 8'h00;
    localparam logic [7:0]    UNMAPPED_READ     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Field layout inside each selector register
    localparam int unsigned   SEL_W             = 3;
    localparam int unsigned   SEL_LO_POS        = 0;
    localparam int unsigned   SEL_HI_POS        = 3;
    localparam int unsigned   RSVD_POS          = 6;
    localparam int unsigned   RSVD_W            = 2;
    localparam logic [1:0]    RSVD_READ_VALUE   = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Channels served by this bank
    localparam int unsigned   NUM_CHAN          = 4;
    localparam int unsigned   NUM_SRC           = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Source codes; the die temperature is read back as
    // (v - 0.69068) / 0.019328 + 25 degC by software
    localparam logic [2:0]    SRC_ANALOG_PIN    = 3'h0;
    localparam logic [2:0]    SRC_DIE_TEMP      = 3'h1;
    localparam logic [2:0]    SRC_REF_X4        = 3'h2;
    localparam logic [2:0]    SRC_ANA_REG_X4    = 3'h3;
    localparam logic [2:0]    SRC_DIG_REG_X4    = 3'h4;
    localparam logic [2:0]    SRC_IO_SUPPLY     = 3'h5;
    localparam logic [2:0]    SRC_ANA_GROUND    = 3'h6;
    localparam logic [2:0]    SRC_ANA_SUPPLY    = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Input range coding handed to the converter front end
    localparam int unsigned   RANGE_W           = 2;
    localparam logic [1:0]    RANGE_PM10V       = 2'h0;
    localparam logic [1:0]    RANGE_RESET       = 2'h0;

    typedef logic [SEL_W-1:0]   sel_t;
    typedef logic [RANGE_W-1:0] range_t;

endpackage : diag_source_pkg

// ===== diag_source_select.sv
// Diagnostic source selector registers for converter channels 1 to 4
//
// Summary of operation
// - Register 0x28 holds channel 2 selector in [5:3], channel 1 in [2:0].
// - Register 0x29 holds channel 4 selector in [5:3], channel 3 in [2:0].
// - Bits [7:6] of both registers are read-only and read as zero.
// - Reset loads 0x00 so every channel starts on its analog pin.
// - Code 000 routes the channel's own analog input pin.
// - Code 001 routes the die temperature sensor.
// - Code 010 routes four times the 2.5 V reference.
// - Code 011 routes four times the 1.8 V analog regulator.
// - Codes 100 to 111: digital regulator, I/O supply, ground, analog supply.
// - Any diagnostic source forces the plus or minus 10 V input range.
`timescale 1ns/1ns

module diag_source_select
    import diag_source_pkg::*;
(
    input  wire logic                              ref_clk,          // 20 MHz clock
    input  wire logic                              sys_rst,          // Sync reset, active high
    input  wire logic [diag_source_pkg::REG_ADDR_W-1:0] reg_addr,    // Register address
    input  wire logic [diag_source_pkg::REG_DATA_W-1:0] reg_wdata,   // Write data
    input  wire logic                              reg_wr,           // Write strobe
    input  wire logic                              reg_rd,           // Read strobe
    output logic      [diag_source_pkg::REG_DATA_W-1:0] reg_rdata,   // Read data
    output logic                                   reg_rd_valid,     // Read data valid pulse
    output logic                                   reg_addr_hit,     // Last read hit this bank
    input  wire logic                              conv_start,       // Conversion start pulse
    input  wire logic [4*diag_source_pkg::RANGE_W-1:0] range_req,    // Programmed ranges
    output logic      [4*diag_source_pkg::SEL_W-1:0]   source_applied, // Sources in use
    output logic      [4*diag_source_pkg::NUM_SRC-1:0] source_onehot,  // Analog switch drive
    output logic      [3:0]                        diag_active,      // Channel on diag node
    output logic      [4*diag_source_pkg::RANGE_W-1:0] range_applied, // Range in use
    output logic      [4*diag_source_pkg::SEL_W-1:0]   source_pending  // Register contents
);

    import diag_source_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Port widths and field slicing are fixed by the register map; refuse
    // package edits the slicing cannot serve rather than let fields overlap
    // or spill silently into the reserved bits.
    if (SEL_HI_POS < SEL_LO_POS + SEL_W) begin : g_chk_overlap
        $error("selector fields overlap");
    end
    if (RSVD_POS != SEL_HI_POS + SEL_W) begin : g_chk_rsvd
        $error("reserved bits do not follow the upper selector");
    end
    if (RSVD_POS + RSVD_W != REG_DATA_W) begin : g_chk_fill
        $error("selector fields do not fill the register");
    end
    if (NUM_SRC != (1 << SEL_W)) begin : g_chk_src
        $error("switch drive must cover every selector code");
    end
    if (NUM_CHAN != 4) begin : g_chk_chan
        $error("port widths assume four channels");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    sel_t   chan1_source_select_q;
    sel_t   chan1_source_select_d;
    sel_t   chan2_source_select_q;
    sel_t   chan2_source_select_d;
    sel_t   chan3_source_select_q;
    sel_t   chan3_source_select_d;
    sel_t   chan4_source_select_q;
    sel_t   chan4_source_select_d;

    logic   wr_sel12;
    logic   wr_sel34;

    assign wr_sel12 = reg_wr && (reg_addr == ADDR_SEL_CH1_CH2);
    assign wr_sel34 = reg_wr && (reg_addr == ADDR_SEL_CH3_CH4);

    // Reserved bits of write data are simply dropped; nothing stores them
    always_comb begin
        chan1_source_select_d = chan1_source_select_q;
        chan2_source_select_d = chan2_source_select_q;
        chan3_source_select_d = chan3_source_select_q;
        chan4_source_select_d = chan4_source_select_q;
        if (wr_sel12) begin
            chan1_source_select_d = reg_wdata[SEL_LO_POS +: SEL_W];
            chan2_source_select_d = reg_wdata[SEL_HI_POS +: SEL_W];
        end
        if (wr_sel34) begin
            chan3_source_select_d = reg_wdata[SEL_LO_POS +: SEL_W];
            chan4_source_select_d = reg_wdata[SEL_HI_POS +: SEL_W];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            chan1_source_select_q <= SEL_REG_RESET[SEL_LO_POS +: SEL_W];
            chan2_source_select_q <= SEL_REG_RESET[SEL_HI_POS +: SEL_W];
            chan3_source_select_q <= SEL_REG_RESET[SEL_LO_POS +: SEL_W];
            chan4_source_select_q <= SEL_REG_RESET[SEL_HI_POS +: SEL_W];
        end else begin
            chan1_source_select_q <= chan1_source_select_d;
            chan2_source_select_q <= chan2_source_select_d;
            chan3_source_select_q <= chan3_source_select_d;
            chan4_source_select_q <= chan4_source_select_d;
        end
    end

    assign source_pending = {chan4_source_select_q, chan3_source_select_q,
                             chan2_source_select_q, chan1_source_select_q};

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [REG_DATA_W-1:0] rdata_q;
    logic [REG_DATA_W-1:0] rdata_d;
    logic                  rd_valid_q;
    logic                  rd_valid_d;
    logic                  hit_q;
    logic                  hit_d;

    // Unmapped reads answer zero so the read path never floats
    always_comb begin
        rdata_d    = rdata_q;
        rd_valid_d = reg_rd;
        hit_d      = hit_q;
        if (reg_rd) begin
            hit_d = 1'b1;
            case (reg_addr)
                ADDR_SEL_CH1_CH2: rdata_d = {RSVD_READ_VALUE,
                                             chan2_source_select_q,
                                             chan1_source_select_q};
                ADDR_SEL_CH3_CH4: rdata_d = {RSVD_READ_VALUE,
                                             chan4_source_select_q,
                                             chan3_source_select_q};
                default: begin
                    rdata_d = UNMAPPED_READ;
                    hit_d   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q    <= UNMAPPED_READ;
            rd_valid_q <= 1'b0;
            hit_q      <= 1'b0;
        end else begin
            rdata_q    <= rdata_d;
            rd_valid_q <= rd_valid_d;
            hit_q      <= hit_d;
        end
    end

    assign reg_rdata    = rdata_q;
    assign reg_rd_valid = rd_valid_q;
    assign reg_addr_hit = hit_q;

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel routing, latched at conversion start

    // Sampling at conv_start keeps a conversion from seeing its source switch
    // half way; a write landing in the same cycle waits for the next one.
    sel_t src_now [NUM_CHAN];

    assign src_now[0] = chan1_source_select_q;
    assign src_now[1] = chan2_source_select_q;
    assign src_now[2] = chan3_source_select_q;
    assign src_now[3] = chan4_source_select_q;

    for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
        sel_t                 applied_q;
        sel_t                 applied_d;
        logic [NUM_SRC-1:0]   onehot_q;
        logic [NUM_SRC-1:0]   onehot_d;
        logic                 diag_q;
        logic                 diag_d;
        range_t               range_q;
        range_t               range_d;

        always_comb begin
            applied_d = applied_q;
            onehot_d  = onehot_q;
            diag_d    = diag_q;
            range_d   = range_q;
            if (conv_start) begin
                applied_d = src_now[ch];
                onehot_d  = '0;
                case (src_now[ch])
                    SRC_ANALOG_PIN: onehot_d[SRC_ANALOG_PIN] = 1'b1;
                    SRC_DIE_TEMP:   onehot_d[SRC_DIE_TEMP]   = 1'b1;
                    SRC_REF_X4:     onehot_d[SRC_REF_X4]     = 1'b1;
                    SRC_ANA_REG_X4: onehot_d[SRC_ANA_REG_X4] = 1'b1;
                    SRC_DIG_REG_X4: onehot_d[SRC_DIG_REG_X4] = 1'b1;
                    SRC_IO_SUPPLY:  onehot_d[SRC_IO_SUPPLY]  = 1'b1;
                    SRC_ANA_GROUND: onehot_d[SRC_ANA_GROUND] = 1'b1;
                    SRC_ANA_SUPPLY: onehot_d[SRC_ANA_SUPPLY] = 1'b1;
                    default:        onehot_d[SRC_ANALOG_PIN] = 1'b1;
                endcase
                diag_d  = (src_now[ch] != SRC_ANALOG_PIN);
                range_d = (src_now[ch] != SRC_ANALOG_PIN) ? RANGE_PM10V
                          : range_req[ch*RANGE_W +: RANGE_W];
            end
        end

        // Reset state matches code 000 on the analog pin, but range loads RANGE_RESET, not the programmed range
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                applied_q <= SRC_ANALOG_PIN;
                onehot_q  <= {{(NUM_SRC-1){1'b0}}, 1'b1};
                diag_q    <= 1'b0;
                range_q   <= RANGE_RESET;
            end else begin
                applied_q <= applied_d;
                onehot_q  <= onehot_d;
                diag_q    <= diag_d;
                range_q   <= range_d;
            end
        end

        assign source_applied[ch*SEL_W +: SEL_W]       = applied_q;
        assign source_onehot[ch*NUM_SRC +: NUM_SRC]    = onehot_q;
        assign diag_active[ch]                         = diag_q;
        assign range_applied[ch*RANGE_W +: RANGE_W]    = range_q;
    end

endmodule : diag_source_select

// ===== diag_source_monitor.sv
// Port-level assertions for the diagnostic source selector bank
`timescale 1ns/1ns
module diag_source_monitor (
    input wire logic        ref_clk,        // Clock
    input wire logic        sys_rst,        // Reset
    input wire logic [7:0]  reg_addr,       // Address
    input wire logic [7:0]  reg_wdata,      // Write data
    input wire logic        reg_wr,         // Write
    input wire logic        reg_rd,         // Read
    input wire logic [7:0]  reg_rdata,      // Read data
    input wire logic        reg_rd_valid,   // Read valid
    input wire logic        conv_start,     // Conversion
    input wire logic [11:0] source_applied, // Sources
    input wire logic [31:0] source_onehot,  // Switches
    input wire logic [3:0]  diag_active,    // Diag flags
    input wire logic [7:0]  range_applied,  // Ranges
    input wire logic [11:0] source_pending  // Fields
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    rd_answer_a: assert property (reg_rd |=> reg_rd_valid) else $error("no read answer");
    rd_quiet_a: assert property (!reg_rd |=> !reg_rd_valid) else $error("stray valid");
    rsvd_zero_a: assert property (reg_rd_valid |-> reg_rdata[7:6] == 2'h0)
        else $error("reserved bits set");
    wr_low_pair_a: assert property (reg_wr && reg_addr == 8'h28
        |=> source_pending[5:0] == $past(reg_wdata[5:0])) else $error("ch1/ch2 write");
    wr_high_pair_a: assert property (reg_wr && reg_addr == 8'h29
        |=> source_pending[11:6] == $past(reg_wdata[5:0])) else $error("ch3/ch4 write");
    conv_latch_a: assert property (conv_start
        |=> source_applied == $past(source_pending)) else $error("latch wrong");
    hold_applied_a: assert property (!conv_start |=> $stable(source_applied))
        else $error("source changed");
    diag_flag_a: assert property (conv_start
        |=> diag_active[0] == ($past(source_pending[2:0]) != 3'h0)) else $error("diag flag");
    switch_drive_a: assert property (conv_start
        |=> source_onehot[15:8] == 8'h01 << $past(source_pending[5:3])) else $error("onehot");
    diag_range_a: assert property (diag_active[3] |-> range_applied[7:6] == 2'h0)
        else $error("range not 10 V");
endmodule : diag_source_monitor

bind diag_source_select diag_source_monitor i_diag_source_monitor (.ref_clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rd_valid, .conv_start,
    .source_applied, .source_onehot, .diag_active, .range_applied, .source_pending);

// ===== diag_source_select_test.sv
// Self-checking bench for the diagnostic source selector bank
`timescale 1ns/1ns
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module diag_source_select_test;
    import diag_source_pkg::*;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        conv_start = 1'b0;
    logic [7:0]  range_req = 8'hb7;
    logic [7:0]  reg_rdata;
    logic        reg_rd_valid;
    logic        reg_addr_hit;
    logic [11:0] source_applied;
    logic [31:0] source_onehot;
    logic [3:0]  diag_active;
    logic [7:0]  range_applied;
    logic [11:0] source_pending;
    logic [2:0]  c3;
    int          num_errors = 0;
    int          num_checks = 0;

    diag_source_select i_diag_source_select (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .reg_rd_valid, .reg_addr_hit, .conv_start, .range_req,
        .source_applied, .source_onehot, .diag_active, .range_applied, .source_pending);

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : reg_write

    // Read answer is exactly one cycle after the strobe, so no wait loop
    task automatic reg_read(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        `CHK(reg_rd_valid, 1'b1)
        `CHK(reg_rdata, e)
        `CHK(reg_addr_hit, h)
    endtask : reg_read

    task automatic convert(input logic [11:0] s);
        logic [31:0] oh;
        logic [3:0]  dg;
        logic [7:0]  rg;
        @(negedge ref_clk);
        conv_start = 1'b1;
        @(negedge ref_clk);
        conv_start = 1'b0;
        for (int i = 0; i < 4; i++) begin
            oh[8*i+:8] = 8'h01 << s[3*i+:3];
            dg[i] = s[3*i+:3] != SRC_ANALOG_PIN;
            rg[2*i+:2] = dg[i] ? RANGE_PM10V : range_req[2*i+:2];
        end
        `CHK(source_applied, s)
        `CHK(source_onehot, oh)
        `CHK(diag_active, dg)
        `CHK(range_applied, rg)
    endtask : convert

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        num_errors++;
        close_out();
    end

    initial begin
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        reg_read(8'h28, 8'h00, 1'b1);
        reg_read(8'h29, 8'h00, 1'b1);
        `CHK(source_onehot, 32'h01010101)
        reg_write(8'h28, 8'hff);
        reg_read(8'h28, 8'h3f, 1'b1);
        reg_write(8'h29, 8'hd1);
        reg_read(8'h29, 8'h11, 1'b1);
        // Unmapped neighbour must answer zero with no hit and not disturb register 0x28
        reg_write(8'h2a, 8'hff);
        reg_read(8'h2a, 8'h00, 1'b0);
        reg_read(8'h28, 8'h3f, 1'b1);
        for (int c = 0; c < 8; c++) begin
            c3 = c[2:0];
            reg_write(8'h28, {2'h3, ~c3, c3});
            reg_write(8'h29, {2'h3, c3, ~c3});
            convert({c3, ~c3, ~c3, c3});
        end
        reg_write(8'h28, 8'h08);
        `CHK(source_applied, 12'he07)
        `CHK(source_pending, 12'he08)
        @(negedge ref_clk);
        sys_rst = 1'b1;
        @(negedge ref_clk);
        sys_rst = 1'b0;
        reg_read(8'h28, 8'h00, 1'b1);
        `CHK(source_applied, 12'h000)
        `CHK(source_onehot, 32'h01010101)
        `CHK(diag_active, 4'h0)
        `CHK(range_applied, 8'h00)
        close_out();
    end
endmodule : diag_source_select_test
